// File: rail_enable_override_pg_delay.sv
// Rail enable override, disable and power-good delay logic
`timescale 1ns/10ps
`default_nettype none
module rail_enable_override_pg_delay #(
  parameter int TICK_CYCLES = rail_pkg::MS_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire rail_pkg::reg_req_s REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [10:0] RAIL_IN_RANGE_I,
  input wire logic [10:0] RAIL_FOLLOW_I,
  input wire logic [10:0] GROUP_ONE_I,
  input wire logic [10:0] GROUP_TWO_I,
  input wire logic [10:0] GROUP_FOUR_I,
  input wire logic [2:0] OUT_SW_MODE_I,
  input wire logic [2:0] OUT_SW_LEVEL_I,
  input wire logic OUT_TWO_TERM_USE_I,
  output logic [2:0] OUT_PIN_O,
  output logic TERM_GOOD_O,
  output logic [10:0] RAIL_EN_O
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] delay_q;
  logic [7:0] disable_q;
  logic [7:0] override_q;
  logic [2:0] step_dis_q;
  logic [2:0] override_two_q;
  logic [10:0] range_s1_q;
  logic [10:0] range_s2_q;
  logic [10:0] follow_s1_q;
  logic [10:0] follow_s2_q;

  // Decode of the register port
  logic wr_delay;
  logic wr_disable;
  logic wr_override;
  logic wr_step;
  logic wr_override_two;
  logic [7:0] rdata_d;
  assign wr_delay = REG_REQ_I.wr && REG_REQ_I.addr == rail_pkg::GOOD_DELAY_OFS;
  assign wr_disable = REG_REQ_I.wr && REG_REQ_I.addr == rail_pkg::DISABLE_OFS;
  assign wr_override =
    REG_REQ_I.wr && REG_REQ_I.addr == rail_pkg::OVERRIDE_ONE_OFS;
  assign wr_step = REG_REQ_I.wr && REG_REQ_I.addr == rail_pkg::STEP_CTRL_OFS;
  assign wr_override_two =
    REG_REQ_I.wr && REG_REQ_I.addr == rail_pkg::OVERRIDE_TWO_OFS;

  // Read mux; unmapped offsets and unheld bits read zero
  assign rdata_d =
    (REG_REQ_I.addr == rail_pkg::GOOD_DELAY_OFS) ? delay_q :
    (REG_REQ_I.addr == rail_pkg::DISABLE_OFS) ? disable_q :
    (REG_REQ_I.addr == rail_pkg::OVERRIDE_ONE_OFS) ? override_q :
    (REG_REQ_I.addr == rail_pkg::STEP_CTRL_OFS) ? {5'h00, step_dis_q} :
    (REG_REQ_I.addr == rail_pkg::OVERRIDE_TWO_OFS) ?
      {4'h0, override_two_q, 1'b0} : rail_pkg::READ_ZERO;

  // Register writes; reserved disable bits are stored as written
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      delay_q <= rail_pkg::GOOD_DELAY_RST;
      disable_q <= rail_pkg::DISABLE_RST;
      override_q <= rail_pkg::OVERRIDE_ONE_RST;
      step_dis_q <= rail_pkg::STEP_DIS_RST;
      override_two_q <= rail_pkg::OVERRIDE_TWO_RST;
    end else begin
      if (wr_delay) delay_q <= REG_REQ_I.wdata;
      if (wr_disable) disable_q <= REG_REQ_I.wdata;
      if (wr_override) override_q <= REG_REQ_I.wdata;
      if (wr_step) step_dis_q <= REG_REQ_I.wdata[2:0];
      if (wr_override_two) override_two_q <= REG_REQ_I.wdata[3:1];
    end
  end

  // Read data is held until the next read
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= rail_pkg::READ_ZERO;
    end else if (REG_REQ_I.rd) begin
      REG_RDATA_O <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers: regulator comparators and control pins are async
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      range_s1_q <= 11'h000;
      range_s2_q <= 11'h000;
      follow_s1_q <= 11'h000;
      follow_s2_q <= 11'h000;
    end else begin
      range_s1_q <= RAIL_IN_RANGE_I;
      range_s2_q <= range_s1_q;
      follow_s1_q <= RAIL_FOLLOW_I;
      follow_s2_q <= follow_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Rail enables: disable beats override, override beats the pin
  // ------------------------------------------------------------------
  logic [10:0] allow;
  logic [10:0] force_on;
  logic [10:0] rail_en_d;
  // Step-down four..six and linear a two have no disable bit here
  assign allow = {disable_q[rail_pkg::TERM_DIS_BIT],
                  disable_q[rail_pkg::SHARED_DIS_BIT],
                  disable_q[rail_pkg::SWITCH_B_ONE_DIS_BIT],
                  1'b1,
                  disable_q[rail_pkg::SWITCH_A_ONE_DIS_BIT],
                  3'h7,
                  step_dis_q};
  assign force_on = {override_two_q[rail_pkg::TERM_ON_BIT - 1],
                     override_two_q[rail_pkg::SHARED_ON_BIT - 1],
                     override_two_q[rail_pkg::SWITCH_B_ONE_ON_BIT - 1],
                     override_q[rail_pkg::LINEAR_A_TWO_ON_BIT],
                     override_q[rail_pkg::SWITCH_A_ONE_ON_BIT],
                     override_q[5:0]};
  assign rail_en_d = allow & (force_on | follow_s2_q);

  // Registered so the regulator enables never glitch
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      RAIL_EN_O <= 11'h000;
    end else begin
      RAIL_EN_O <= rail_en_d;
    end
  end

  // ------------------------------------------------------------------
  // Delay code decode
  // ------------------------------------------------------------------
  logic [2:0] code_two;
  logic [2:0] code_four;
  logic [1:0] code_one;
  logic [6:0] ms_two;
  logic [6:0] ms_four;
  logic [6:0] ms_one;
  assign code_two = delay_q[rail_pkg::TWO_DLY_LSB +: 3];
  assign code_four = delay_q[rail_pkg::FOUR_DLY_LSB +: 3];
  assign code_one = delay_q[rail_pkg::ONE_DLY_LSB +: 2];
  // Codes 101 and 110 fall through to zero
  assign ms_two =
    (code_two == 3'h1) ? rail_pkg::DLY_5_MS :
    (code_two == 3'h2) ? rail_pkg::DLY_10_MS :
    (code_two == 3'h3) ? rail_pkg::DLY_15_MS :
    (code_two == 3'h4) ? rail_pkg::DLY_20_MS :
    (code_two == 3'h7) ? rail_pkg::DLY_50_MS : rail_pkg::DLY_0_MS;
  // Code 010 taken as 10 ms; 110 falls through to zero
  assign ms_four =
    (code_four == 3'h1) ? rail_pkg::DLY_5_MS :
    (code_four == 3'h2) ? rail_pkg::DLY_10_MS :
    (code_four == 3'h3) ? rail_pkg::DLY_15_MS :
    (code_four == 3'h4) ? rail_pkg::DLY_20_MS :
    (code_four == 3'h5) ? rail_pkg::DLY_50_MS :
    (code_four == 3'h7) ? rail_pkg::DLY_100_MS : rail_pkg::DLY_0_MS;
  assign ms_one =
    (code_one == 2'h1) ? rail_pkg::DLY_5_MS :
    (code_one == 2'h2) ? rail_pkg::DLY_10_MS :
    (code_one == 2'h3) ? rail_pkg::DLY_15_MS : rail_pkg::DLY_0_MS;

  // ------------------------------------------------------------------
  // Good timers, one per output: index 0 one, 1 two, 2 four
  // ------------------------------------------------------------------
  logic [2:0] group_good;
  logic [2:0] clear;
  logic [2:0] timed_good;
  logic [6:0] ms_sel [3];
  logic [2:0] pin_d;
  assign group_good = {&(range_s2_q | ~GROUP_FOUR_I),
                       &(range_s2_q | ~GROUP_TWO_I),
                       &(range_s2_q | ~GROUP_ONE_I)};
  assign ms_sel[0] = ms_one;
  assign ms_sel[1] = ms_two;
  assign ms_sel[2] = ms_four;
  // Output two keeps timing when it also gates the termination rail
  assign clear = ~group_good |
                 (OUT_SW_MODE_I & {1'b1, ~OUT_TWO_TERM_USE_I, 1'b1});

  generate
    for (genvar g = 0; g < 3; g++) begin : g_out
      good_delay_timer #(
        .TICK_CYCLES(TICK_CYCLES)
      ) u_timer (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .clear_i(clear[g]),
        .delay_ms_i(ms_sel[g]),
        .good_o(timed_good[g])
      );
    end
  endgenerate

  // Software level replaces the timed good in software mode
  assign pin_d = (OUT_SW_MODE_I & OUT_SW_LEVEL_I) |
                 (~OUT_SW_MODE_I & timed_good);

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      OUT_PIN_O <= 3'h0;
    end else begin
      OUT_PIN_O <= pin_d;
    end
  end

  assign TERM_GOOD_O = timed_good[1];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_shared_off;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !disable_q[rail_pkg::SHARED_DIS_BIT]
      |=> !RAIL_EN_O[rail_pkg::RAIL_SHARED];
  endproperty
  a_shared_off: assert property (p_shared_off)
    else $error("shared rail on while disabled");
  property p_switch_b_one_off;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !disable_q[rail_pkg::SWITCH_B_ONE_DIS_BIT]
      |=> !RAIL_EN_O[rail_pkg::RAIL_SWITCH_B_ONE];
  endproperty
  a_switch_b_one_off: assert property (p_switch_b_one_off)
    else $error("switch b one on while disabled");
  property p_term_off;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !disable_q[rail_pkg::TERM_DIS_BIT] |=> !RAIL_EN_O[rail_pkg::RAIL_TERM];
  endproperty
  a_term_off: assert property (p_term_off)
    else $error("termination on while disabled");
  property p_linear_a_two_force;
    @(posedge CLK_I) disable iff (!RESETN_I)
      override_q[rail_pkg::LINEAR_A_TWO_ON_BIT]
      |=> RAIL_EN_O[rail_pkg::RAIL_LINEAR_A_TWO];
  endproperty
  a_linear_a_two_force: assert property (p_linear_a_two_force)
    else $error("linear a two not forced on");
  property p_switch_a_one_force;
    @(posedge CLK_I) disable iff (!RESETN_I)
      override_q[rail_pkg::SWITCH_A_ONE_ON_BIT] &&
      disable_q[rail_pkg::SWITCH_A_ONE_DIS_BIT]
      |=> RAIL_EN_O[rail_pkg::RAIL_SWITCH_A_ONE];
  endproperty
  a_switch_a_one_force: assert property (p_switch_a_one_force)
    else $error("switch a one not forced on");
  property p_step_force;
    @(posedge CLK_I) disable iff (!RESETN_I)
      override_q[5] |=> RAIL_EN_O[5];
  endproperty
  a_step_force: assert property (p_step_force)
    else $error("step-down six not forced on");
  property p_step_dis;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !step_dis_q[2] |=> !RAIL_EN_O[2];
  endproperty
  a_step_dis: assert property (p_step_dis)
    else $error("step-down three on while disabled");
  property p_follow;
    @(posedge CLK_I) disable iff (!RESETN_I)
      !override_q[0] && step_dis_q[0]
      |=> RAIL_EN_O[0] == $past(follow_s2_q[0]);
  endproperty
  a_follow: assert property (p_follow)
    else $error("step-down one ignored its control pin");

  property p_undef_zero;
    @(posedge CLK_I) disable iff (!RESETN_I)
      code_two == 3'h5 || code_two == 3'h6 |-> ms_two == rail_pkg::DLY_0_MS;
  endproperty
  a_undef_zero: assert property (p_undef_zero)
    else $error("undefined delay code gave nonzero delay");

endmodule // rail_enable_override_pg_delay
`default_nettype wire

// File: rail_pkg.sv
// Shared constants and carrier types for the rail enable and good-delay block
package rail_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] STEP_CTRL_OFS = 8'h9c;
  localparam logic [7:0] GOOD_DELAY_OFS = 8'h9d;
  localparam logic [7:0] DISABLE_OFS = 8'h9f;
  localparam logic [7:0] OVERRIDE_ONE_OFS = 8'ha0;
  localparam logic [7:0] OVERRIDE_TWO_OFS = 8'ha1;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int TWO_DLY_LSB = 5;
  localparam int FOUR_DLY_LSB = 2;
  localparam int ONE_DLY_LSB = 0;
  localparam int SHARED_DIS_BIT = 7;
  localparam int SWITCH_B_ONE_DIS_BIT = 6;
  localparam int SWITCH_A_ONE_DIS_BIT = 5;
  localparam int TERM_DIS_BIT = 4;
  localparam int LINEAR_A_TWO_ON_BIT = 7;
  localparam int SWITCH_A_ONE_ON_BIT = 6;
  localparam int TERM_ON_BIT = 3;
  localparam int SHARED_ON_BIT = 2;
  localparam int SWITCH_B_ONE_ON_BIT = 1;

  // ------------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------------
  localparam logic [7:0] GOOD_DELAY_RST = 8'h00;
  localparam logic [7:0] DISABLE_RST = 8'hf0;
  localparam logic [7:0] OVERRIDE_ONE_RST = 8'h00;
  localparam logic [2:0] STEP_DIS_RST = 3'h7;
  localparam logic [2:0] OVERRIDE_TWO_RST = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ------------------------------------------------------------------
  // Rails: 0..5 step-down one..six, then the rest
  // ------------------------------------------------------------------
  localparam int RAILS = 11;
  localparam int RAIL_SWITCH_A_ONE = 6;
  localparam int RAIL_LINEAR_A_TWO = 7;
  localparam int RAIL_SWITCH_B_ONE = 8;
  localparam int RAIL_SHARED = 9;
  localparam int RAIL_TERM = 10;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [6:0] DLY_0_MS = 7'h00;
  localparam logic [6:0] DLY_5_MS = 7'h05;
  localparam logic [6:0] DLY_10_MS = 7'h0a;
  localparam logic [6:0] DLY_15_MS = 7'h0f;
  localparam logic [6:0] DLY_20_MS = 7'h14;
  localparam logic [6:0] DLY_50_MS = 7'h32;
  localparam logic [6:0] DLY_100_MS = 7'h64;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// File: good_delay_timer.sv
// Power-good delay timer for one general output
`timescale 1ns/10ps
`default_nettype none
module good_delay_timer #(
  parameter int TICK_CYCLES = rail_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic [6:0] delay_ms_i,
  output logic good_o
);

  logic [15:0] sub_q;
  logic [6:0] ms_q;
  logic tick;
  logic done;

  // ------------------------------------------------------------------
  // Millisecond divider, restarted with the timer for an exact start
  // ------------------------------------------------------------------
  assign tick = (sub_q == 16'(TICK_CYCLES - 1));
  assign done = (ms_q >= delay_ms_i);

  // Sub-millisecond count
  always_ff @(posedge clk_i) begin
    if (!resetn_i || clear_i || tick) begin
      sub_q <= 16'h0000;
    end else begin
      sub_q <= sub_q + 16'h0001;
    end
  end

  // Timing starts only once every grouped rail is in range
  always_ff @(posedge clk_i) begin
    if (!resetn_i || clear_i) begin
      ms_q <= 7'h00;
      good_o <= 1'b0;
    end else if (done) begin
      good_o <= 1'b1;
    end else if (tick) begin
      ms_q <= ms_q + 7'h01;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_clear_drops;
    @(posedge clk_i) disable iff (!resetn_i) clear_i |=> !good_o;
  endproperty
  a_clear_drops: assert property (p_clear_drops)
    else $error("good stayed up while rails out of range");

  property p_rise_cause;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(good_o) |-> !$past(clear_i) && $past(ms_q) >= $past(delay_ms_i);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("good rose before its delay elapsed");

  property p_zero_fast;
    @(posedge clk_i) disable iff (!resetn_i)
      (!clear_i && delay_ms_i == 7'h00) |=> good_o;
  endproperty
  a_zero_fast: assert property (p_zero_fast)
    else $error("zero delay did not assert good next cycle");

endmodule // good_delay_timer
`default_nettype wire

// File: reg_host_model.sv
// Register host model that drives the block's register request port
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output var rail_pkg::reg_req_s req_o
);
  // ----------------------------------------------------------------
  // Idle state and single-byte transfers
  // ----------------------------------------------------------------
  // Strobes start low so nothing is taken while reset is held
  initial begin
    req_o = '0;
  end

  // One write pulse; released data is inverted so stale bytes never match
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] wd;
    wd = (addr == rail_pkg::DISABLE_OFS) ? (data & 8'hf0) : data;
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: wd};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: ~wd};
  endtask

  // One read pulse; data is taken once the answering edge has settled
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: addr, wdata: 8'hff};
    #1;
    data = rdata_i;
  endtask
endmodule // reg_host_model
`default_nettype wire

// File: rail_enable_override_pg_delay_tb.sv
// Self-checking testbench for the rail enable and good-delay block
`timescale 1ns/10ps
`default_nettype none
module rail_enable_override_pg_delay_tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int TICK = 4; // Short millisecond keeps the longest delay brief
  localparam int MS_ONE[4] = '{0, 5, 10, 15};
  localparam int MS_TWO[8] = '{0, 5, 10, 15, 20, 0, 0, 50};
  localparam int MS_FOUR[8] = '{0, 5, 10, 15, 20, 50, 0, 100};
  logic clk;
  logic resetn;
  rail_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic [10:0] in_range, follow, grp_one, grp_two, grp_four, rail_en;
  logic [2:0] sw_mode, sw_level, out_pin;
  logic term_use, term_good;
  int num_errors = 0;
  int total_checks = 0;

  rail_enable_override_pg_delay #(.TICK_CYCLES(TICK))
      rail_enable_override_pg_delay_inst (
    .CLK_I(clk), .RESETN_I(resetn), .REG_REQ_I(req), .REG_RDATA_O(rdata),
    .RAIL_IN_RANGE_I(in_range), .RAIL_FOLLOW_I(follow),
    .GROUP_ONE_I(grp_one), .GROUP_TWO_I(grp_two), .GROUP_FOUR_I(grp_four),
    .OUT_SW_MODE_I(sw_mode), .OUT_SW_LEVEL_I(sw_level),
    .OUT_TWO_TERM_USE_I(term_use), .OUT_PIN_O(out_pin),
    .TERM_GOOD_O(term_good), .RAIL_EN_O(rail_en));

  reg_host_model reg_host_model_inst (.clk_i(clk), .rdata_i(rdata),
    .req_o(req));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    reg_host_model_inst.read_reg(addr, d);
    check({24'h0, d}, {24'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped access and reserved bits of the disable byte
  task automatic test_reset_regs();
    check({21'h0, rail_en}, 32'h0);
    rd_chk(rail_pkg::GOOD_DELAY_OFS, 8'h00);
    rd_chk(rail_pkg::DISABLE_OFS, 8'hf0);
    rd_chk(rail_pkg::OVERRIDE_ONE_OFS, 8'h00);
    rd_chk(rail_pkg::STEP_CTRL_OFS, 8'h07);
    rd_chk(rail_pkg::OVERRIDE_TWO_OFS, 8'h00);
    reg_host_model_inst.write_reg(8'h9e, 8'h5a);
    rd_chk(8'h9e, 8'h00);
    reg_host_model_inst.write_reg(rail_pkg::DISABLE_OFS, 8'hff);
    rd_chk(rail_pkg::DISABLE_OFS, 8'hf0);
    $display("test reset_regs done");
  endtask

  // Pin following, disables and overrides, disable always winning
  task automatic test_rails();
    @(posedge clk);
    follow <= 11'h7ff;
    wait_cyc(4);
    check({21'h0, rail_en}, 32'h7ff);
    reg_host_model_inst.write_reg(rail_pkg::DISABLE_OFS, 8'h00);
    wait_cyc(3);
    check({21'h0, rail_en}, 32'h0bf);
    @(posedge clk);
    follow <= 11'h000;
    reg_host_model_inst.write_reg(rail_pkg::OVERRIDE_ONE_OFS, 8'hff);
    reg_host_model_inst.write_reg(rail_pkg::OVERRIDE_TWO_OFS, 8'h0e);
    wait_cyc(4);
    check({21'h0, rail_en}, 32'h0bf);
    reg_host_model_inst.write_reg(rail_pkg::DISABLE_OFS, 8'hf0);
    wait_cyc(3);
    check({21'h0, rail_en}, 32'h7ff);
    reg_host_model_inst.write_reg(rail_pkg::STEP_CTRL_OFS, 8'h00);
    wait_cyc(3);
    check({21'h0, rail_en}, 32'h7f8);
    reg_host_model_inst.write_reg(rail_pkg::STEP_CTRL_OFS, 8'h07);
    reg_host_model_inst.write_reg(rail_pkg::OVERRIDE_ONE_OFS, 8'h00);
    reg_host_model_inst.write_reg(rail_pkg::OVERRIDE_TWO_OFS, 8'h00);
    wait_cyc(3);
    check({21'h0, rail_en}, 32'h0);
    $display("test rails done");
  endtask

  // Time from all grouped rails in range to the good pin rising
  task automatic measure(input int idx, input int lsb, input logic [2:0] code,
                         input int ms);
    int n;
    @(posedge clk);
    in_range <= 11'h000;
    reg_host_model_inst.write_reg(rail_pkg::GOOD_DELAY_OFS,
                                  8'(code) << lsb);
    wait_cyc(4);
    check({31'h0, out_pin[idx]}, 32'h0);
    @(posedge clk);
    in_range <= 11'h7ff;
    n = 0;
    while (out_pin[idx] !== 1'b1 && n < 800) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 800) begin
      num_errors++;
      give_verdict();
    end
    // Sync, timer start and pin flop add a few cycles to the nominal count
    check({31'h0, (n >= ms * TICK + 3 && n <= ms * TICK + 7)}, 32'h1);
  endtask

  // Every code of every delay field, undefined codes meaning zero
  task automatic test_delays();
    for (int c = 0; c < 4; c++) begin
      measure(0, 0, 3'(c), MS_ONE[c]);
    end
    for (int c = 0; c < 8; c++) begin
      measure(1, 5, 3'(c), MS_TWO[c]);
    end
    for (int c = 0; c < 8; c++) begin
      measure(2, 2, 3'(c), MS_FOUR[c]);
    end
    // One rail of output four's two-rail group drops; the others stay good
    @(posedge clk);
    in_range <= 11'h7f7;
    wait_cyc(4);
    check({29'h0, out_pin}, 32'h3);
    $display("test delays done");
  endtask

  // Software-driven outputs ignore delay and rail state
  task automatic test_sw_mode();
    @(posedge clk);
    in_range <= 11'h000;
    sw_mode <= 3'b111;
    sw_level <= 3'b101;
    reg_host_model_inst.write_reg(rail_pkg::GOOD_DELAY_OFS, 8'hff);
    wait_cyc(4);
    check({29'h0, out_pin}, 32'h5);
    @(posedge clk);
    sw_level <= 3'b010;
    in_range <= 11'h7ff;
    wait_cyc(3);
    check({29'h0, out_pin}, 32'h2);
    check({31'h0, term_good}, 32'h0);
    reg_host_model_inst.write_reg(rail_pkg::GOOD_DELAY_OFS, 8'h00);
    @(posedge clk);
    term_use <= 1'b1;
    wait_cyc(8);
    check({31'h0, term_good}, 32'h1);
    check({29'h0, out_pin}, 32'h2);
    $display("test sw_mode done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    in_range = 11'h000;
    follow = 11'h000;
    grp_one = 11'h001;
    grp_two = 11'h002;
    grp_four = 11'h00c; // Two rails so the whole group must be in range
    sw_mode = 3'b000;
    sw_level = 3'b000;
    term_use = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    #1;
    test_reset_regs();
    test_rails();
    test_delays();
    test_sw_mode();
    give_verdict();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule // rail_enable_override_pg_delay_tb
`default_nettype wire
